// [fhc_pkg.sv]
package fhc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] FHC_IDX_TX_STATUS = 8'h06;
    localparam logic [7:0] FHC_IDX_TX_CODE_CMD = 8'h07;
    localparam logic [7:0] FHC_IDX_TX_FIFO = 8'h08;
    localparam logic [7:0] FHC_IDX_TX_FIFO_LAST = 8'h09;
    localparam logic [7:0] FHC_IDX_RX_CHAN_CTL = 8'h90;

    // tx_link_code_command fields
    localparam int FHC_CMD_TRIGGER_BIT = 7;
    localparam int FHC_CMD_CTL_EN_BIT = 6;
    localparam int FHC_CODE_W = 6;
    localparam logic [2:0] FHC_CODE_BITS = 3'h6;

    // rx_packet_channel_control fields
    localparam int FHC_RXC_MODE_EN_BIT = 7;
    localparam int FHC_RXC_RSVD_BIT = 6;
    localparam int FHC_RXC_SEL_MODE_BIT = 5;
    localparam int FHC_RXC_NUM_W = 5;

    // Transmit status fields
    localparam int FHC_STS_UNDERRUN_BIT = 0;
    localparam int FHC_STS_FULL_BIT = 1;
    localparam int FHC_STS_EMPTY_BIT = 2;

    // Reset values
    localparam logic [7:0] FHC_CMD_RESET = 8'h00;
    localparam logic [7:0] FHC_RXC_RESET = 8'h00;

    // Transmit packet queue geometry
    localparam int FHC_FIFO_DEPTH = 16;
    localparam int FHC_PTR_W = 4;
    localparam logic [FHC_PTR_W:0] FHC_FIFO_FULL = 5'h10;
    localparam logic [2:0] FHC_LAST_BIT_IDX = 3'h7;

    localparam int FHC_NUM_CHAN = 24;

    typedef enum logic [1:0] {
        FHC_TX_IDLE = 2'b00,
        FHC_TX_PKT = 2'b01,
        FHC_TX_CODE = 2'b11
    } fhc_tx_st_e;

    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic [7:0] cmd;
        logic [7:0] rxc;
        logic [FHC_FIFO_DEPTH-1:0][8:0] mem;
        logic [FHC_PTR_W-1:0] wptr;
        logic [FHC_PTR_W-1:0] rptr;
        logic [FHC_PTR_W:0] count;
        fhc_tx_st_e st;
        logic byte_vld;
        logic [7:0] sh;
        logic sh_last;
        logic [2:0] bitcnt;
        logic [FHC_CODE_W-1:0] code_sh;
        logic [2:0] code_cnt;
        logic underrun;
        logic ack;
        logic [7:0] dat;
        logic link_out;
        logic rx_use_link;
        logic [FHC_NUM_CHAN-1:0] rx_mask;
    } fhc_state_s;

endpackage

// [fhc_top.sv]
`timescale 1ns/1ns
module fhc_top
    import fhc_pkg::*;
(
    // Clock, reset, enable
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [11:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Transmit link
    input wire logic I_EXT_LINK_DATA_PIN,
    input wire logic I_TX_LINK_BIT_EN,
    output logic O_TX_LINK_DATA,
    // Receive routing
    input wire logic [23:0] I_RX_CHANNEL_BLOCK_SELECT,
    output logic O_RX_USE_LINK,
    output logic [23:0] O_RX_CHANNEL_MASK
);

    fhc_state_s q;
    fhc_state_s d;

    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic [7:0] wb_idx;
    logic trig_rise;
    logic fifo_wr;
    logic fifo_pop;
    logic underrun_ev;
    logic [8:0] fifo_in;
    logic ctl_bit;

    function automatic logic [FHC_NUM_CHAN-1:0] chan_onehot(
        input logic [FHC_RXC_NUM_W-1:0] num
    );
        logic [FHC_NUM_CHAN-1:0] m;
        m = '0;
        for (int i = 0; i < FHC_NUM_CHAN; i++) begin
            if (num == i[FHC_RXC_NUM_W-1:0]) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    always_comb begin
        d = q;
        wb_req = I_WB_CYC && I_WB_STB && !q.ack && (I_WB_ADR[11:10] == 2'h0);
        wb_idx = I_WB_ADR[9:2];
        wb_wr = wb_req && I_WB_WE && I_WB_SEL[0];
        wb_rd = wb_req && !I_WB_WE;
        trig_rise = 1'b0;
        fifo_wr = 1'b0;
        fifo_pop = 1'b0;
        underrun_ev = 1'b0;
        fifo_in = {1'b0, I_WB_DAT[7:0]};

        d.ext_s1 = I_EXT_LINK_DATA_PIN;
        d.ext_s2 = q.ext_s1;

        // Bus answer one cycle after the request; ack drops the cycle after
        d.ack = I_WB_CYC && I_WB_STB && !q.ack;
        d.dat = 8'h00;
        if (wb_idx == FHC_IDX_TX_STATUS) begin
            d.dat[FHC_STS_UNDERRUN_BIT] = q.underrun;
            d.dat[FHC_STS_FULL_BIT] = (q.count == FHC_FIFO_FULL);
            d.dat[FHC_STS_EMPTY_BIT] = (q.count == '0);
        end else if (wb_idx == FHC_IDX_TX_CODE_CMD) begin
            d.dat = q.cmd;
        end else if (wb_idx == FHC_IDX_RX_CHAN_CTL) begin
            d.dat = q.rxc;
        end
        if (!wb_rd) begin
            d.dat = 8'h00;
        end

        if (wb_wr) begin
            if (wb_idx == FHC_IDX_TX_CODE_CMD) begin
                d.cmd = I_WB_DAT[7:0];
                trig_rise = I_WB_DAT[FHC_CMD_TRIGGER_BIT]
                    && !q.cmd[FHC_CMD_TRIGGER_BIT];
            end else if (wb_idx == FHC_IDX_TX_FIFO) begin
                fifo_wr = 1'b1;
            end else if (wb_idx == FHC_IDX_TX_FIFO_LAST) begin
                fifo_wr = 1'b1;
                fifo_in[8] = 1'b1;
            end else if (wb_idx == FHC_IDX_RX_CHAN_CTL) begin
                d.rxc = I_WB_DAT[7:0];
                d.rxc[FHC_RXC_RSVD_BIT] = 1'b0;
            end
        end

        // Link serialiser, stepped by the link bit strobe
        if (trig_rise) begin
            d.st = FHC_TX_CODE;
            d.code_sh = I_WB_DAT[FHC_CODE_W-1:0];
            d.code_cnt = FHC_CODE_BITS;
        end else if (I_TX_LINK_BIT_EN) begin
            if (q.st == FHC_TX_CODE) begin
                // Codeword bits replace packet bits; packet is held meanwhile
                d.code_sh = q.code_sh >> 1;
                d.code_cnt = q.code_cnt - 3'h1;
                if (q.code_cnt == 3'h1) begin
                    d.st = q.byte_vld ? FHC_TX_PKT : FHC_TX_IDLE;
                end
            end else if (q.cmd[FHC_CMD_CTL_EN_BIT]) begin
                if (!q.byte_vld) begin
                    fifo_pop = (q.count != '0);
                end else begin
                    d.sh = q.sh >> 1;
                    d.bitcnt = q.bitcnt + 3'h1;
                    if (q.bitcnt == FHC_LAST_BIT_IDX) begin
                        d.byte_vld = 1'b0;
                        fifo_pop = !q.sh_last && (q.count != '0);
                        underrun_ev = !q.sh_last && (q.count == '0);
                    end
                end
                if (fifo_pop) begin
                    d.byte_vld = 1'b1;
                    d.sh = q.mem[q.rptr][7:0];
                    d.sh_last = q.mem[q.rptr][8];
                    d.bitcnt = 3'h0;
                end
                d.st = d.byte_vld ? FHC_TX_PKT : FHC_TX_IDLE;
            end
        end

        // Full queue drops the written byte
        if (fifo_wr && (q.count != FHC_FIFO_FULL)) begin
            d.mem[q.wptr] = fifo_in;
            d.wptr = q.wptr + 1'b1;
        end
        if (fifo_pop) begin
            d.rptr = q.rptr + 1'b1;
        end
        d.count = q.count + {4'h0, fifo_wr && (q.count != FHC_FIFO_FULL)}
            - {4'h0, fifo_pop};

        // Read clears the flag, but a new underrun in that cycle wins
        if (wb_rd && (wb_idx == FHC_IDX_TX_STATUS)) begin
            d.underrun = 1'b0;
        end
        if (underrun_ev) begin
            d.underrun = 1'b1;
        end

        ctl_bit = (q.st == FHC_TX_CODE) ? q.code_sh[0]
            : (q.byte_vld ? q.sh[0] : 1'b1);
        d.link_out = q.cmd[FHC_CMD_CTL_EN_BIT] ? ctl_bit : q.ext_s2;

        // Receive controller routing
        if (!q.rxc[FHC_RXC_MODE_EN_BIT]) begin
            d.rx_use_link = 1'b1;
            d.rx_mask = '0;
        end else if (!q.rxc[FHC_RXC_SEL_MODE_BIT]) begin
            d.rx_use_link = 1'b0;
            d.rx_mask = chan_onehot(q.rxc[FHC_RXC_NUM_W-1:0]);
        end else begin
            d.rx_use_link = 1'b0;
            d.rx_mask = I_RX_CHANNEL_BLOCK_SELECT;
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            q <= '0;
            q.cmd <= FHC_CMD_RESET;
            q.rxc <= FHC_RXC_RESET;
            q.st <= FHC_TX_IDLE;
            q.link_out <= 1'b1;
            q.rx_use_link <= 1'b1;
        end else if (I_CE) begin
            q <= d;
        end
    end

    assign O_WB_DAT = {24'h000000, q.dat};
    assign O_WB_ACK = q.ack;
    assign O_TX_LINK_DATA = q.link_out;
    assign O_RX_USE_LINK = q.rx_use_link;
    assign O_RX_CHANNEL_MASK = q.rx_mask;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    AST_CODE_START: assert property (
        (I_CE && trig_rise) |=> (q.st == FHC_TX_CODE)
            && (q.code_cnt == FHC_CODE_BITS))
        else $error("codeword send did not start on trigger edge");
    AST_LINK_FROM_PIN: assert property (
        (I_CE && !q.cmd[FHC_CMD_CTL_EN_BIT])
            |=> (O_TX_LINK_DATA == $past(q.ext_s2)))
        else $error("link data not taken from pin");
    AST_LINK_FROM_CODE: assert property (
        (I_CE && q.cmd[FHC_CMD_CTL_EN_BIT] && q.st == FHC_TX_CODE)
            |=> (O_TX_LINK_DATA == $past(q.code_sh[0])))
        else $error("link data not taken from codeword");
    AST_CODE_LSB_FIRST: assert property (
        (I_CE && I_TX_LINK_BIT_EN && q.st == FHC_TX_CODE && !trig_rise)
            |=> (q.code_sh == {1'b0, $past(q.code_sh[5:1])}))
        else $error("codeword not shifted lsb first");
    AST_CODE_COUNT: assert property (
        (q.st == FHC_TX_CODE) |-> (q.code_cnt >= 3'h1 && q.code_cnt <= 3'h6))
        else $error("codeword bit count out of range");
    AST_FIFO_QUEUE: assert property (
        (I_CE && fifo_wr && q.count != FHC_FIFO_FULL)
            |=> (q.mem[$past(q.wptr)][7:0] == $past(I_WB_DAT[7:0])))
        else $error("written byte not queued");
    AST_RX_LINK_MODE: assert property (
        (I_CE && !q.rxc[FHC_RXC_MODE_EN_BIT])
            |=> (O_RX_USE_LINK && O_RX_CHANNEL_MASK == '0))
        else $error("receive controller not on data link");
    AST_RX_SINGLE: assert property (
        (I_CE && q.rxc[FHC_RXC_MODE_EN_BIT] && !q.rxc[FHC_RXC_SEL_MODE_BIT])
            |=> (O_RX_CHANNEL_MASK == chan_onehot($past(q.rxc[4:0]))))
        else $error("single channel mask wrong");
    AST_RX_BLOCK: assert property (
        (I_CE && q.rxc[FHC_RXC_MODE_EN_BIT] && q.rxc[FHC_RXC_SEL_MODE_BIT])
            |=> (O_RX_CHANNEL_MASK == $past(I_RX_CHANNEL_BLOCK_SELECT)))
        else $error("block channel mask wrong");
    AST_UNDERRUN_SET: assert property (
        (I_CE && underrun_ev) |=> q.underrun)
        else $error("underrun flag not latched");
    AST_ACK_ONE_CYCLE: assert property (
        (I_CE && O_WB_ACK) |=> !O_WB_ACK)
        else $error("ack held longer than one cycle");
    AST_ACK_ANSWER: assert property (
        (I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK)
        else $error("bus request not answered in one cycle");

    // Status and queue bookkeeping
    AST_STATUS_READ: assert property (
        (I_CE && wb_rd && wb_idx == FHC_IDX_TX_STATUS)
            |=> (O_WB_DAT[FHC_STS_UNDERRUN_BIT] == $past(q.underrun)
            && O_WB_DAT[FHC_STS_EMPTY_BIT] == ($past(q.count) == '0)))
        else $error("status read data wrong");
    AST_UNDERRUN_CLEAR: assert property (
        (I_CE && wb_rd && wb_idx == FHC_IDX_TX_STATUS && !underrun_ev)
            |=> !q.underrun)
        else $error("underrun flag not cleared by read");
    AST_FIFO_DROP: assert property (
        (I_CE && fifo_wr && q.count == FHC_FIFO_FULL && !fifo_pop)
            |=> (q.count == FHC_FIFO_FULL && $stable(q.wptr)))
        else $error("write to full queue not dropped");

    // Link source and codeword sequencing
    AST_PIN_SYNC: assert property (
        I_CE |=> (q.ext_s2 == $past(q.ext_s1)))
        else $error("link pin synchroniser skipped a stage");
    AST_PKT_HELD: assert property (
        (I_CE && q.st == FHC_TX_CODE) |=> ($stable(q.sh)
            && $stable(q.bitcnt) && $stable(q.byte_vld)))
        else $error("packet moved while codeword was sent");
    AST_CODE_RETURN: assert property (
        (I_CE && I_TX_LINK_BIT_EN && q.st == FHC_TX_CODE
            && q.code_cnt == 3'h1 && !trig_rise) |=> (q.st != FHC_TX_CODE))
        else $error("codeword did not end after its sixth bit");

    // Receive routing
    AST_RX_LINK_OFF: assert property (
        (I_CE && q.rxc[FHC_RXC_MODE_EN_BIT]) |=> !O_RX_USE_LINK)
        else $error("receive controller still on data link");
    AST_RX_SINGLE_ONEHOT: assert property (
        (I_CE && q.rxc[FHC_RXC_MODE_EN_BIT] && !q.rxc[FHC_RXC_SEL_MODE_BIT]
            && q.rxc[4:0] < 5'h18) |=> $onehot(O_RX_CHANNEL_MASK))
        else $error("single channel mode chose other than one channel");
    AST_RX_RSVD_ZERO: assert property (
        !q.rxc[FHC_RXC_RSVD_BIT])
        else $error("unassigned receive control bit stored as one");

    COV_CODE_SENT: cover property (
        (q.st == FHC_TX_CODE) ##1 (q.st != FHC_TX_CODE));
    COV_UNDERRUN: cover property (underrun_ev);
    COV_RX_BLOCK: cover property (
        q.rxc[FHC_RXC_MODE_EN_BIT] && q.rxc[FHC_RXC_SEL_MODE_BIT]);
    COV_FIFO_FULL: cover property (q.count == FHC_FIFO_FULL);
    COV_LAST_BYTE: cover property (I_CE && fifo_wr && fifo_in[8]);

endmodule

// [tb_fhc_top.sv]
`timescale 1ns/1ns
module tb_fhc_top;
import fhc_pkg::*;
logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pin = 0, ben = 0, ok;
logic [11:0] adr = '0;
logic [3:0] sel = 4'hF;
logic [31:0] wdat = '0, rdat, dat_o;
logic ack, lnk, use_lnk;
logic [23:0] blk = '0, mask, em;
logic [7:0] v, b;
logic [5:0] c;
logic [15:0] cap;
logic ce = 1'b1, und_m = 1'b0;
logic [8:0] e;
logic [8:0] fq[$];
int fails = 0, compares = 0;

always #2 clk = ~clk;

fhc_top fhc_top_inst(.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(dat_o), .O_WB_ACK(ack),
    .I_EXT_LINK_DATA_PIN(pin), .I_TX_LINK_BIT_EN(ben),
    .O_TX_LINK_DATA(lnk), .I_RX_CHANNEL_BLOCK_SELECT(blk),
    .O_RX_USE_LINK(use_lnk), .O_RX_CHANNEL_MASK(mask));

task automatic wrap_up;
    if (fails == 0 && compares > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask

task automatic chk(input string n, input logic [31:0] e,
                   input logic [31:0] g);
    compares++;
    if (g !== e) begin
        $display("MISMATCH %s expected %h seen %h", n, e, g);
        fails++;
    end
endtask

// Classic single cycle; entered just after a rising edge
task automatic bus(input logic w, input logic [7:0] idx,
                   input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
        @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
endtask

// One link bit strobe, then let the output settle
task automatic strobe;
    ben <= 1'b1;
    @(posedge clk);
    ben <= 1'b0;
    repeat (2) @(posedge clk);
endtask

// Model of the status word: bit 2 empty, bit 1 full, bit 0 underrun
function automatic logic [31:0] stat_m();
    return {29'h0, fq.size() == 0, fq.size() == FHC_FIFO_DEPTH, und_m};
endfunction

task automatic stat_chk(input string n);
    bus(0, FHC_IDX_TX_STATUS, 8'h00);
    chk(n, stat_m(), rdat);
    und_m = 1'b0;
endtask

// Queue one byte; the model drops it when the queue is full
task automatic push(input logic last, input logic [7:0] x);
    bus(1, last ? FHC_IDX_TX_FIFO_LAST : FHC_IDX_TX_FIFO, x);
    if (fq.size() < FHC_FIFO_DEPTH)
        fq.push_back({last, x});
endtask

initial begin
    #100000;
    fails++;
    wrap_up;
end

initial begin
    void'($urandom(75));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, FHC_IDX_TX_CODE_CMD, 8'h00);
    chk("cmd reset", {24'h0, FHC_CMD_RESET}, rdat);
    bus(0, FHC_IDX_RX_CHAN_CTL, 8'h00);
    chk("rxc reset", {24'h0, FHC_RXC_RESET}, rdat);
    bus(0, FHC_IDX_TX_STATUS, 8'h00);
    stat_chk("status reset");
    bus(0, 8'h55, 8'h00);
    chk("unmapped", 32'h0, rdat);
    for (int i = 0; i < 8; i++) begin
        v = 8'($urandom);
        v[7] = i[0];
        v[5] = i[1];
        v[6] = 1'b0;
        blk <= 24'($urandom);
        bus(1, FHC_IDX_RX_CHAN_CTL, v);
        sel <= 4'h0;
        bus(1, FHC_IDX_RX_CHAN_CTL, 8'hBF);
        sel <= 4'hF;
        bus(0, FHC_IDX_RX_CHAN_CTL, 8'h00);
        chk("rxc", {24'h0, v & 8'hBF}, rdat);
        repeat (3) @(posedge clk);
        chk("use link", {31'h0, ~v[7]}, {31'h0, use_lnk});
        em = v[5] ? blk : (v[4:0] < 5'h18 ? 24'h1 << v[4:0] : 24'h0);
        if (!v[7])
            em = '0;
        chk("mask", {8'h0, em}, {8'h0, mask});
    end
    bus(1, FHC_IDX_TX_CODE_CMD, 8'h00);
    for (int i = 0; i < 4; i++) begin
        pin <= i[0];
        repeat (5) @(posedge clk);
        chk("pin path", {31'h0, i[0]}, {31'h0, lnk});
    end
    for (int k = 0; k < 3; k++) begin
        c = 6'($urandom);
        bus(1, FHC_IDX_TX_CODE_CMD, {2'b01, c});
        bus(1, FHC_IDX_TX_CODE_CMD, {2'b11, c});
        @(posedge clk);
        chk("code bit", {31'h0, c[0]}, {31'h0, lnk});
        for (int i = 1; i < 6; i++) begin
            strobe;
            chk("code bit", {31'h0, c[i]}, {31'h0, lnk});
        end
        bus(0, FHC_IDX_TX_CODE_CMD, 8'h00);
        chk("cmd", {24'h0, 2'b11, c}, rdat);
    end
    bus(1, FHC_IDX_TX_CODE_CMD, 8'h40);
    // First byte not marked last (underrun), second marked last
    for (int p = 0; p < 2; p++) begin
        b = {1'b0, 6'($urandom), 1'b0};
        push(p[0], b);
        cap = '0;
        repeat (16) begin
            strobe;
            cap = {lnk, cap[15:1]};
        end
        e = fq.pop_front();
        if (!e[8] && fq.size() == 0)
            und_m = 1'b1;
        ok = 1'b0;
        for (int j = 0; j < 9; j++)
            if (cap[j+:8] === e[7:0])
                ok = 1'b1;
        chk("packet byte", 32'h1, {31'h0, ok});
        stat_chk("underrun set");
        stat_chk("underrun clear");
    end
    bus(1, FHC_IDX_TX_CODE_CMD, 8'h00);
    for (int i = 0; i < FHC_FIFO_DEPTH + 1; i++)
        push(1'b0, 8'($urandom));
    stat_chk("fifo full");
    ce <= 1'b0;
    pin <= ~pin;
    repeat (5) @(posedge clk);
    chk("ce freeze", {31'h0, ~pin}, {31'h0, lnk});
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ce run", {31'h0, pin}, {31'h0, lnk});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    fq.delete();
    @(posedge clk);
    bus(0, FHC_IDX_RX_CHAN_CTL, 8'h00);
    chk("rxc rerun", {24'h0, FHC_RXC_RESET}, rdat);
    chk("use link rerun", 32'h1, {31'h0, use_lnk});
    stat_chk("status rerun");
    wrap_up;
end
endmodule
